// [src/io_lane_slip_dev.sv]
`timescale 1ns/1ns
`include "lane_slip_cfg.svh"
module io_lane_slip_dev
#(
  parameter int LANE_IODS = `LANE_IODS,
  parameter int BANK_CLKS = `BANK_CLKS
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  lane_slip_if.device_mp            lane,
  output logic                      rx_iod_gclk_en,
  output logic                      tx_oe_iod_gclk_en,
  output logic [LANE_IODS-1:0]      lane_clk_en,
  output logic                      regional_src_cdr,
  output logic                      regional_src_fast,
  output logic [BANK_CLKS-1:0]      bank_fast_clock_en,
  output logic [BANK_CLKS-1:0]      ccc_ref_feed,
  output logic                      bank_src_ccc_out,
  output logic                      bridge_en,
  output logic                      bridge_refused,
  output logic                      fast_clk_gate
);

  // refuse sizes the fanout and the struct cannot carry
  generate
    if (LANE_IODS != `LANE_IODS || BANK_CLKS < 1 || BANK_CLKS > `BANK_CLKS)
    begin : g_bad_param
      $error("unsupported clock counts");
    end
  endgenerate

  typedef struct packed {
    logic [`SYNC_DEPTH-1:0]  slip_s;
    logic                    slip_lvl;
    logic [`SYNC_DEPTH-1:0]  rst_s;
    logic                    rst_lvl;
    logic                    pend;
    logic [3:0]              bit_cnt;
    logic [`HIST_W-1:0]      hist;
    logic [3:0]              pos;
    logic                    back_next;
    logic [`WORD_MAX_W-1:0]  word;
    logic                    word_v;
    logic                    done;
    logic                    gate;
    logic                    rx_g;
    logic                    tx_g;
    logic [LANE_IODS-1:0]    lane_en;
    logic                    reg_cdr;
    logic                    reg_fast;
    logic [BANK_CLKS-1:0]    bank_en;
    logic [BANK_CLKS-1:0]    ccc_feed;
    logic                    src_ccc;
    logic                    bridge;
    logic                    bridge_no;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;
  logic [LANE_IODS-1:0] lane_fan;

  // next first-bit position after one slip
  function automatic logic [3:0] next_pos
  (
    input lane_slip_pkg::gear_mode_t gear,
    input logic [3:0]                pos,
    input logic                      back
  );
    logic [3:0] w;
    w = lane_slip_pkg::word_width(gear);
    if (back && gear != lane_slip_pkg::gear_x2_mode)
      next_pos = (pos >= `STEP_BACK) ? pos - `STEP_BACK : pos + w - `STEP_BACK;
    else
      next_pos = (pos >= w - `STEP_FWD) ? `POS_START : pos + `STEP_FWD;
  endfunction : next_pos

  // word of w bits starting w-pos bits into the older word, or at its first bit when pos is 0
  function automatic logic [`WORD_MAX_W-1:0] extract
  (
    input logic [`HIST_W-1:0] hist,
    input logic [3:0]         pos,
    input logic [3:0]         w
  );
    int idx;
    extract = '0;
    for (int i = 0; i < `WORD_MAX_W; i++)
    begin
      idx = ((pos == 4'h0) ? 2 * int'(w) : int'(w) + int'(pos)) - 1 - i;
      if (i < int'(w) && idx >= 0)
        extract[int'(w) - 1 - i] = hist[idx];
    end
  endfunction : extract

  generate
    for (genvar g = 0; g < LANE_IODS; g++)
    begin : g_lane_fan
      assign lane_fan[g] = (|lane.bank_clk_use) & ~state_next.gate;
    end
  endgenerate

  // lane state: syncs, deserializer, slip order, clock enables
  always_comb
  begin
    logic [3:0] w;
    logic       slip_edge;
    logic       iod_rst;
    logic       boundary;
    logic       take;
    w         = lane_slip_pkg::word_width(lane.gear_mode);
    state_next = state_reg;

    // three-stage sync, edge once stages agree
    state_next.slip_s = {state_reg.slip_s[`SYNC_DEPTH-2:0], lane.lane_word_slip_req};
    state_next.rst_s  = {state_reg.rst_s[`SYNC_DEPTH-2:0], lane.iod_async_reset_n};
    slip_edge = 1'b0;
    if (state_reg.slip_s[1] == state_reg.slip_s[2])
    begin
      state_next.slip_lvl = state_reg.slip_s[2];
      slip_edge = state_reg.slip_s[2] & ~state_reg.slip_lvl;
    end
    if (state_reg.rst_s[1] == state_reg.rst_s[2])
      state_next.rst_lvl = state_reg.rst_s[2];
    iod_rst = ~state_reg.rst_lvl;

    // shift the serial stream, newest bit at the bottom
    state_next.hist = {state_reg.hist[`HIST_W-2:0], lane.ser_bit};
    boundary = (state_reg.bit_cnt >= w - 4'h1);
    state_next.bit_cnt = boundary ? 4'h0 : state_reg.bit_cnt + 4'h1;

    // x3.5 and a disabled slip function ignore requests
    take = slip_edge & lane.word_slip_function &
           (lane.gear_mode != lane_slip_pkg::gear_x3p5_mode);
    state_next.word_v = boundary;
    state_next.done   = 1'b0;
    state_next.gate   = 1'b0;
    // at most one slip applied per word boundary
    if (boundary && state_reg.pend)
    begin
      state_next.pos = next_pos(lane.gear_mode, state_reg.pos, state_reg.back_next);
      // steps alternate in x4 and x5
      if (lane.gear_mode != lane_slip_pkg::gear_x2_mode)
        state_next.back_next = ~state_reg.back_next;
      state_next.gate = 1'b1;
      state_next.done = 1'b1;
    end
    // a new edge in the applying cycle is kept, set beats clear
    state_next.pend = (state_reg.pend & ~boundary) | take;

    // deliver the word rotated by the slip position
    if (boundary)
      state_next.word = extract(state_reg.hist, state_next.pos, w);

    // block reset restarts order with minus three in x4 and x5, plus one in x2
    if (iod_rst)
    begin
      state_next.pos       = `POS_START;
      state_next.back_next = 1'b1;
      state_next.pend      = 1'b0;
      state_next.gate      = 1'b0;
      state_next.done      = 1'b0;
    end

    // receive and transmit/enable global clocks kept apart
    state_next.rx_g = lane.rx_gclk_run;
    state_next.tx_g = lane.tx_oe_gclk_run;
    // regional buffer takes one source only
    state_next.reg_cdr  = lane.regional_from_cdr;
    state_next.reg_fast = ~lane.regional_from_cdr;
    // six bank fast clocks, gated by slip suppression
    state_next.bank_en = lane.bank_clk_use[BANK_CLKS-1:0] & {BANK_CLKS{~state_next.gate}};
    // pin-sourced fast clocks may feed neighbour conditioners
    state_next.src_ccc  = lane.bank_src_ccc;
    state_next.ccc_feed = lane.bank_clk_use[BANK_CLKS-1:0] & {BANK_CLKS{~lane.bank_src_ccc}};
    state_next.bridge    = lane.bridge_req & lane.fractional_rx;
    state_next.bridge_no = lane.bridge_req & ~lane.fractional_rx;
    state_next.lane_en   = lane_fan;

    if (!rst_b)
    begin
      state_next = '0;
      state_next.back_next = 1'b1;
    end
  end

  // single register for all lane state
  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  // outputs straight from the state register
  assign lane.rx_word       = state_reg.word;
  assign lane.rx_word_valid = state_reg.word_v;
  assign lane.slip_done     = state_reg.done;
  assign rx_iod_gclk_en     = state_reg.rx_g;
  assign tx_oe_iod_gclk_en  = state_reg.tx_g;
  assign lane_clk_en        = state_reg.lane_en;
  assign regional_src_cdr   = state_reg.reg_cdr;
  assign regional_src_fast  = state_reg.reg_fast;
  assign bank_fast_clock_en = state_reg.bank_en;
  assign ccc_ref_feed       = state_reg.ccc_feed;
  assign bank_src_ccc_out   = state_reg.src_ccc;
  assign bridge_en          = state_reg.bridge;
  assign bridge_refused     = state_reg.bridge_no;
  // low for the one suppressed fast pulse
  assign fast_clk_gate      = ~state_reg.gate;

endmodule : io_lane_slip_dev

// [src/io_lane_slip_trainer.sv]
`timescale 1ns/1ns
`include "lane_slip_cfg.svh"
module io_lane_slip_trainer
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  lane_slip_if.fabric_mp                  lane,
  input  wire logic                       start_train,
  input  wire logic                       block_reset,
  input  wire lane_slip_pkg::gear_mode_t  gear_sel,
  input  wire logic                       slip_enable,
  input  wire logic [`WORD_MAX_W-1:0]     pattern,
  input  wire logic                       rx_gclk_on,
  input  wire logic                       tx_oe_gclk_on,
  input  wire logic                       use_ccc_source,
  input  wire logic [`BANK_CLKS-1:0]      bank_clk_sel,
  input  wire logic                       regional_cdr_sel,
  input  wire logic                       bridge_want,
  input  wire logic                       fractional_mode,
  output logic                            busy,
  output logic                            aligned,
  output logic                            align_fail,
  output logic [3:0]                      slip_count
);

  typedef struct packed {
    lane_slip_pkg::trn_state_t  st;
    logic [`WORD_MAX_W-1:0]     src;
    logic                       req;
    logic [2:0]                 hold;
    logic [1:0]                 settle;
    logic [3:0]                 tries;
    logic                       ok;
    logic                       fail;
    logic                       rst_n;
    lane_slip_pkg::gear_mode_t  gear;
    logic                       fn;
    logic                       rxg;
    logic                       txg;
    logic                       ccc;
    logic [`BANK_CLKS-1:0]      bank;
    logic                       recovered_clock;
    logic                       brq;
    logic                       frac;
  } trn_reg_t;

  trn_reg_t state_reg;
  trn_reg_t state_next;

  // serial source, training loop and registered lane controls
  always_comb
  begin
    logic [3:0] w;
    logic       match;
    w = lane_slip_pkg::word_width(state_reg.gear);
    state_next = state_reg;
    // rotating serial source, one marker bit loaded at reset
    state_next.src = '0;
    for (int i = 0; i < `WORD_MAX_W; i++)
      if (i < int'(w))
        state_next.src[i] = state_reg.src[(i == 0) ? int'(w) - 1 : i - 1];
    match = 1'b1;
    for (int i = 0; i < `WORD_MAX_W; i++)
      if (i < int'(w) && lane.rx_word[i] != pattern[i])
        match = 1'b0;
    state_next.rst_n = ~block_reset;
    state_next.gear  = gear_sel;
    state_next.fn    = slip_enable;
    state_next.rxg   = rx_gclk_on;
    state_next.txg   = tx_oe_gclk_on;
    state_next.ccc   = use_ccc_source;
    state_next.bank  = bank_clk_sel;
    state_next.recovered_clock   = regional_cdr_sel;
    state_next.brq   = bridge_want;
    state_next.frac  = fractional_mode;
    case (state_reg.st)
      lane_slip_pkg::trn_idle:
        if (start_train)
        begin
          state_next.tries  = 4'h0;
          state_next.ok     = 1'b0;
          state_next.fail   = 1'b0;
          state_next.settle = 2'h0;
          // x3.5 has no slip, report fail at once
          if (state_reg.gear == lane_slip_pkg::gear_x3p5_mode || !state_reg.fn)
          begin
            state_next.fail = 1'b1;
            state_next.st   = lane_slip_pkg::trn_done;
          end
          else
            state_next.st = lane_slip_pkg::trn_check;
        end
      lane_slip_pkg::trn_req:
      begin
        // a clean rising edge, then dropped
        state_next.req  = 1'b1;
        state_next.hold = state_reg.hold + 3'h1;
        if (state_reg.hold >= `SLIP_HOLD - 3'h1)
        begin
          state_next.req    = 1'b0;
          state_next.hold   = 3'h0;
          state_next.settle = 2'h0;
          state_next.st     = lane_slip_pkg::trn_gap;
        end
      end
      lane_slip_pkg::trn_gap:
        if (lane.slip_done)
          state_next.st = lane_slip_pkg::trn_check;
      lane_slip_pkg::trn_check:
        // evaluate settled word, slip again if wrong
        if (lane.rx_word_valid)
        begin
          state_next.settle = state_reg.settle + 2'h1;
          if (state_reg.settle >= `SETTLE_WORDS - 2'h1)
          begin
            if (match)
            begin
              state_next.ok = 1'b1;
              state_next.st = lane_slip_pkg::trn_done;
            end
            else if (state_reg.tries >= w)
            begin
              state_next.fail = 1'b1;
              state_next.st   = lane_slip_pkg::trn_done;
            end
            else
            begin
              state_next.tries = state_reg.tries + 4'h1;
              state_next.st    = lane_slip_pkg::trn_req;
            end
          end
        end
      default:
        if (!start_train)
          state_next.st = lane_slip_pkg::trn_idle;
    endcase
    if (!rst_b)
    begin
      state_next       = '0;
      state_next.st    = lane_slip_pkg::trn_idle;
      state_next.src   = `WORD_MAX_W'(1);
      state_next.gear  = lane_slip_pkg::gear_x2_mode;
    end
  end

  // single register for the trainer
  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  assign lane.ser_bit            = state_reg.src[0];
  assign lane.lane_word_slip_req = state_reg.req;
  assign lane.iod_async_reset_n  = state_reg.rst_n;
  assign lane.gear_mode          = state_reg.gear;
  assign lane.word_slip_function = state_reg.fn;
  assign lane.rx_gclk_run        = state_reg.rxg;
  assign lane.tx_oe_gclk_run     = state_reg.txg;
  assign lane.bank_src_ccc       = state_reg.ccc;
  assign lane.bank_clk_use       = state_reg.bank;
  assign lane.regional_from_cdr  = state_reg.recovered_clock;
  assign lane.bridge_req         = state_reg.brq;
  assign lane.fractional_rx      = state_reg.frac;
  assign busy                    = (state_reg.st != lane_slip_pkg::trn_idle) &&
                                   (state_reg.st != lane_slip_pkg::trn_done);
  assign aligned                 = state_reg.ok;
  assign align_fail              = state_reg.fail;
  assign slip_count              = state_reg.tries;

endmodule : io_lane_slip_trainer

// [src/lane_slip_cfg.svh]
`ifndef LANE_SLIP_CFG_SVH
`define LANE_SLIP_CFG_SVH
// Functional notes
// - separate receive and transmit/enable global clocks
// - lane clock reaches all twelve data blocks
// - one regional buffer, recovered or fast source
// - up to six bank fast clocks
// - bridging only for fractional receive interfaces
// - fast clocks from pins or conditioning blocks
// - synchronized slip suppresses exactly one pulse
// - fabric starts slip with rising edge
// - one slip per word; x2 steps one bit, x4/x5 alternate minus three and plus one
// - slip enable rotates delivered parallel word
// - trainer evaluates, slips, repeats until aligned or w slips used
// - x2: positions 0,1,2,3 round robin
// - x4: 0,5,6,3,4,1,2,7 alternating steps
// - x4: first slip after reset is minus three
// - x5: 0,7,8,5,6,3,4,1,2,9 cycle
// - x5: first slip after reset minus three
// - x3.5: no slip, fabric aligns itself

// word widths per gearing, bits per parallel word
`define GEAR_W_X2    4'h4
`define GEAR_W_X3P5  4'h7
`define GEAR_W_X4    4'h8
`define GEAR_W_X5    4'hA
`define WORD_MAX_W   10
`define HIST_W       20
// slip step sizes
`define STEP_BACK    4'h3
`define STEP_FWD     4'h1
`define POS_START    4'h0
// clock resource counts
`define LANE_IODS    12
`define BANK_CLKS    6
`define SYNC_DEPTH   3
// trainer timing
`define SLIP_HOLD    3'h4
`define SETTLE_WORDS 2'h2
`endif

// [src/lane_slip_if.sv]
`timescale 1ns/1ns
`include "lane_slip_cfg.svh"
interface lane_slip_if
(
  input wire logic ref_clk
);
  // fabric side to lane
  logic                          ser_bit;
  logic                          lane_word_slip_req;
  logic                          iod_async_reset_n;
  lane_slip_pkg::gear_mode_t     gear_mode;
  logic                          word_slip_function;
  logic                          rx_gclk_run;
  logic                          tx_oe_gclk_run;
  logic                          bank_src_ccc;
  logic [`BANK_CLKS-1:0]         bank_clk_use;
  logic                          regional_from_cdr;
  logic                          bridge_req;
  logic                          fractional_rx;
  // lane to fabric side
  logic [`WORD_MAX_W-1:0]        rx_word;
  logic                          rx_word_valid;
  logic                          slip_done;

  modport device_mp
  (
    input  ser_bit, lane_word_slip_req, iod_async_reset_n, gear_mode, word_slip_function,
    input  rx_gclk_run, tx_oe_gclk_run, bank_src_ccc, bank_clk_use, regional_from_cdr,
    input  bridge_req, fractional_rx,
    output rx_word, rx_word_valid, slip_done
  );

  modport fabric_mp
  (
    output ser_bit, lane_word_slip_req, iod_async_reset_n, gear_mode, word_slip_function,
    output rx_gclk_run, tx_oe_gclk_run, bank_src_ccc, bank_clk_use, regional_from_cdr,
    output bridge_req, fractional_rx,
    input  rx_word, rx_word_valid, slip_done
  );
endinterface : lane_slip_if

// [src/lane_slip_pkg.sv]
`include "lane_slip_cfg.svh"
package lane_slip_pkg;

  typedef enum logic [1:0] {
    gear_x2_mode   = 2'h0,
    gear_x3p5_mode = 2'h1,
    gear_x4_mode   = 2'h2,
    gear_x5_mode   = 2'h3
  } gear_mode_t;

  typedef enum logic [4:0] {
    trn_idle  = 5'h01,
    trn_req   = 5'h02,
    trn_gap   = 5'h04,
    trn_check = 5'h08,
    trn_done  = 5'h10
  } trn_state_t;

  // bits per parallel word for a gearing
  function automatic logic [3:0] word_width(input gear_mode_t gear);
    case (gear)
      gear_x2_mode:   word_width = `GEAR_W_X2;
      gear_x3p5_mode: word_width = `GEAR_W_X3P5;
      gear_x4_mode:   word_width = `GEAR_W_X4;
      default:        word_width = `GEAR_W_X5;
    endcase
  endfunction : word_width

endpackage : lane_slip_pkg

// [tb/io_lane_word_slip_alignment_monitor.sv]
`timescale 1ns/1ns
`include "lane_slip_cfg.svh"
module io_lane_word_slip_alignment_monitor
(
  input wire logic                      ref_clk,
  input wire logic                      rst_b,
  input wire logic                      lane_word_slip_req,
  input wire logic                      iod_async_reset_n,
  input wire lane_slip_pkg::gear_mode_t gear_mode,
  input wire logic                      word_slip_function,
  input wire logic [`WORD_MAX_W-1:0]    rx_word,
  input wire logic                      rx_word_valid,
  input wire logic                      slip_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // age of last request edge, saturating
  logic [4:0] since_req_reg;
  logic       req_d_reg;
  logic       done_seen_reg;
  always_ff @(posedge ref_clk)
  begin
    req_d_reg <= lane_word_slip_req;
    if (!rst_b)
    begin
      since_req_reg <= 5'h1F;
      done_seen_reg <= 1'b1;
    end
    else if (lane_word_slip_req && !req_d_reg)
    begin
      since_req_reg <= 5'h00;
      done_seen_reg <= 1'b0;
    end
    else
    begin
      if (since_req_reg != 5'h1F)
        since_req_reg <= since_req_reg + 5'h01;
      if (slip_done)
        done_seen_reg <= 1'b1;
    end
  end

  property p_done_pulse; slip_done |=> !slip_done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done width");
  property p_done_boundary; slip_done |-> rx_word_valid; endproperty
  a_done_boundary: assert property (p_done_boundary)
    else $error("done off boundary");
  property p_word_spacing; rx_word_valid |=> !rx_word_valid [*3]; endproperty
  a_word_spacing: assert property (p_word_spacing)
    else $error("word spacing");
  property p_word_hold; !rx_word_valid |-> $stable(rx_word); endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word unstable");
  property p_no_slip_x3p5; gear_mode == lane_slip_pkg::gear_x3p5_mode |-> !slip_done; endproperty
  a_no_slip_x3p5: assert property (p_no_slip_x3p5)
    else $error("x3.5 slip");
  property p_block_reset; !iod_async_reset_n [*4] |-> !slip_done; endproperty
  a_block_reset: assert property (p_block_reset)
    else $error("slip in reset");
  property p_slip_cause; slip_done |-> since_req_reg <= 5'h14; endproperty
  a_slip_cause: assert property (p_slip_cause)
    else $error("slip uncaused");
  property p_one_per_edge; slip_done |-> !done_seen_reg; endproperty
  a_one_per_edge: assert property (p_one_per_edge)
    else $error("double slip");
  property p_slip_answer;
    $rose(lane_word_slip_req) && word_slip_function && iod_async_reset_n &&
      gear_mode != lane_slip_pkg::gear_x3p5_mode |-> ##[2:20] slip_done;
  endproperty
  a_slip_answer: assert property (p_slip_answer)
    else $error("no slip");
endmodule : io_lane_word_slip_alignment_monitor

// [tb/io_lane_word_slip_alignment_tb_top.sv]
`timescale 1ns/1ns
`include "lane_slip_cfg.svh"
module io_lane_word_slip_alignment_tb_top;
  logic                      ref_clk;
  logic                      rst_b;
  logic                      start_train;
  logic                      block_reset;
  lane_slip_pkg::gear_mode_t gear_sel;
  logic [`WORD_MAX_W-1:0]    pattern;
  logic [6:0]                cfg;  // slip en, fractional, bridge, regional cdr, ccc, txoe, rx
  logic [5:0]                bank_clk_sel;
  logic                      busy, aligned, align_fail, gate2;
  logic [3:0]                slip_count;
  logic                      rx_en, txoe_en, reg_cdr, reg_fast, ccc_out, br_en, br_ref, gate1;
  logic [11:0]               lane_en;
  logic [5:0]                bank_en, ccc_feed;
  logic [`WORD_MAX_W-1:0]    wv;
  int                        err_total, checks, cyc, ph, wd, dn;

  lane_slip_if lane (.ref_clk(ref_clk));
  lane_slip_if lane2 (.ref_clk(ref_clk));

  io_lane_slip_trainer io_lane_slip_trainer_i (.ref_clk(ref_clk), .rst_b(rst_b), .lane(lane),
    .start_train(start_train), .block_reset(block_reset), .gear_sel(gear_sel),
    .slip_enable(cfg[6]), .pattern(pattern), .rx_gclk_on(cfg[0]), .tx_oe_gclk_on(cfg[1]),
    .use_ccc_source(cfg[2]), .bank_clk_sel(bank_clk_sel), .regional_cdr_sel(cfg[3]),
    .bridge_want(cfg[4]), .fractional_mode(cfg[5]), .busy(busy), .aligned(aligned),
    .align_fail(align_fail), .slip_count(slip_count));
  io_lane_slip_dev io_lane_slip_dev_i (.ref_clk(ref_clk), .rst_b(rst_b), .lane(lane),
    .rx_iod_gclk_en(rx_en), .tx_oe_iod_gclk_en(txoe_en), .lane_clk_en(lane_en),
    .regional_src_cdr(reg_cdr), .regional_src_fast(reg_fast), .bank_fast_clock_en(bank_en),
    .ccc_ref_feed(ccc_feed), .bank_src_ccc_out(ccc_out), .bridge_en(br_en),
    .bridge_refused(br_ref), .fast_clk_gate(gate1));
  // bench-driven device for slip order, refusal and held request tests
  io_lane_slip_dev io_lane_slip_dev_solo_i (.ref_clk(ref_clk), .rst_b(rst_b), .lane(lane2),
    .rx_iod_gclk_en(), .tx_oe_iod_gclk_en(), .lane_clk_en(), .regional_src_cdr(),
    .regional_src_fast(), .bank_fast_clock_en(), .ccc_ref_feed(), .bank_src_ccc_out(),
    .bridge_en(), .bridge_refused(), .fast_clk_gate(gate2));
  io_lane_word_slip_alignment_monitor io_lane_word_slip_alignment_monitor_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .lane_word_slip_req(lane.lane_word_slip_req),
    .iod_async_reset_n(lane.iod_async_reset_n), .gear_mode(lane.gear_mode),
    .word_slip_function(lane.word_slip_function), .rx_word(lane.rx_word),
    .rx_word_valid(lane.rx_word_valid), .slip_done(lane.slip_done));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // one marker bit per word: each rotation distinct
  always @(posedge ref_clk)
  begin
    #2;
    lane2.ser_bit = (ph == 0);
    ph = (ph + 1 >= wd) ? 0 : ph + 1;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s: %0h vs %0h", $time, what, seen, exp);
    end
  endtask : chk

  // first bit on top; a slip moves it toward bit 0
  function automatic logic [`WORD_MAX_W-1:0] rotr(input logic [9:0] v, input int n, input int w);
    rotr = 10'h000;
    for (int i = 0; i < w; i++)
      rotr[(i + w - n) % w] = v[i];
  endfunction : rotr

  task automatic iod2;
    lane2.iod_async_reset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2 lane2.iod_async_reset_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #2;
  endtask : iod2

  task automatic word2(output logic [`WORD_MAX_W-1:0] wrd);
    wrd = 10'h3FF;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (lane2.rx_word_valid === 1'b1)
      begin
        wrd = lane2.rx_word & ~(10'h3FF << wd);
        n = 20;
      end
    end
    #1;
  endtask : word2

  // request for hold cycles, count slips
  task automatic slip2(input int hold, output logic [`WORD_MAX_W-1:0] wrd, output int dones);
    dones = 0;
    wrd = 10'h000;
    @(posedge ref_clk);
    #2 lane2.lane_word_slip_req = 1'b1;
    for (int n = 1; n <= 40; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (lane2.slip_done === 1'b1)
      begin
        dones++;
        wrd = lane2.rx_word & ~(10'h3FF << wd);
        chk(gate2, 1'b0, "gate");
      end
      #1;
      if (n == hold)
        lane2.lane_word_slip_req = 1'b0;
    end
  endtask : slip2

  task automatic gear_run(input lane_slip_pkg::gear_mode_t g, input int w);
    logic [`WORD_MAX_W-1:0] base;
    int                     pos;
    logic                   back;
    lane2.gear_mode = g;
    wd = w;
    iod2();
    word2(base);
    chk($countones(base), 1, "marker");
    pos = 0;
    back = 1'b1;
    for (int k = 0; k <= w; k++)
    begin
      if (g == lane_slip_pkg::gear_x2_mode)
        pos = (pos + 1) % w;
      else
        pos = back ? (pos + w - 3) % w : (pos + 1) % w;
      back = !back;
      slip2(4, wv, dn);
      chk(dn, 1, "dones");
      chk(wv, rotr(base, pos, w), "order");
    end
    // block reset brings back the opening step
    iod2();
    word2(base);
    slip2(4, wv, dn);
    chk(wv, rotr(base, (g == lane_slip_pkg::gear_x2_mode) ? 1 : w - 3, w), "restart");
  endtask : gear_run

  task automatic refuse(input lane_slip_pkg::gear_mode_t g, input int w, input logic en);
    logic [`WORD_MAX_W-1:0] base;
    lane2.gear_mode = g;
    lane2.word_slip_function = en;
    wd = w;
    iod2();
    word2(base);
    slip2(4, wv, dn);
    chk(dn, 0, "ref done");
    word2(wv);
    chk(wv, base, "ref word");
  endtask : refuse

  task automatic train(input lane_slip_pkg::gear_mode_t g, input int w, input logic ok);
    int n;
    rst_b = 1'b0;
    gear_sel = g;
    repeat (4) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    block_reset = 1'b1;
    repeat (4) @(posedge ref_clk);
    #2 block_reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2 start_train = 1'b1;
    @(posedge ref_clk);
    #2 start_train = 1'b0;
    n = 0;
    while (aligned !== 1'b1 && align_fail !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(aligned, ok, "aligned");
    chk(busy, 1'b0, "busy");
    chk(align_fail, !ok, "fail");
    chk(ok ? (slip_count < w) : slip_count, ok, "total");
    @(posedge ref_clk);
    #2;
  endtask : train

  task automatic cfg_chk(input logic [6:0] c, input logic [5:0] b);
    cfg = c;
    bank_clk_sel = b;
    repeat (4) @(posedge ref_clk);
    #1;
    chk({rx_en, txoe_en}, {c[0], c[1]}, "gclk");
    chk(lane_en, 12'hFFF, "lane");
    chk({reg_cdr, reg_fast}, {c[3], !c[3]}, "regional");
    chk(bank_en, b, "bank");
    chk({br_en, br_ref}, {c[5], !c[5]}, "bridge");
    chk({ccc_out, ccc_feed}, {c[2], c[2] ? 6'h00 : b}, "source");
    #1;
  endtask : cfg_chk

  initial
  begin
    err_total = 0;
    checks = 0;
    cyc = 0;
    ph = 0;
    wd = 4;
    rst_b = 1'b0;
    start_train = 1'b0;
    block_reset = 1'b0;
    gear_sel = lane_slip_pkg::gear_x2_mode;
    pattern = 10'h001;
    cfg = 7'h59;
    bank_clk_sel = 6'h15;
    lane2.ser_bit = 1'b0;
    lane2.lane_word_slip_req = 1'b0;
    lane2.iod_async_reset_n = 1'b0;
    lane2.gear_mode = lane_slip_pkg::gear_x2_mode;
    lane2.word_slip_function = 1'b1;
    lane2.rx_gclk_run = 1'b1;
    lane2.tx_oe_gclk_run = 1'b1;
    lane2.bank_src_ccc = 1'b0;
    lane2.bank_clk_use = 6'h3F;
    lane2.regional_from_cdr = 1'b0;
    lane2.bridge_req = 1'b0;
    lane2.fractional_rx = 1'b0;
    repeat (12) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    gear_run(lane_slip_pkg::gear_x2_mode, 4);
    gear_run(lane_slip_pkg::gear_x4_mode, 8);
    gear_run(lane_slip_pkg::gear_x5_mode, 10);
    refuse(lane_slip_pkg::gear_x3p5_mode, 7, 1'b1);
    refuse(lane_slip_pkg::gear_x4_mode, 8, 1'b0);
    // held request slips once
    lane2.word_slip_function = 1'b1;
    slip2(30, wv, dn);
    chk(dn, 1, "held");
    train(lane_slip_pkg::gear_x2_mode, 4, 1'b1);
    train(lane_slip_pkg::gear_x4_mode, 8, 1'b1);
    train(lane_slip_pkg::gear_x5_mode, 10, 1'b1);
    train(lane_slip_pkg::gear_x3p5_mode, 7, 1'b0);
    cfg_chk(7'h59, 6'h15);
    cfg_chk(7'h76, 6'h2A);
    stop_test();
  end
endmodule : io_lane_word_slip_alignment_tb_top
